/* File: core/prc_defs.svh */
// Constants for the partial array refresh controller
`ifndef PRC_DEFS_SVH
`define PRC_DEFS_SVH

// Clock period in ns at 20 MHz
`define PRC_CLK_NS 50
// Word address width and row width inside one block
`define PRC_ADDR_W 22
`define PRC_ROW_W 12

// Longest mode-set low time that still allows normal access, ns
`define PRC_LOW_MAX_NS 500
// Longest time rounds down to whole cycles
`define PRC_LOW_MAX_CYC ((`PRC_LOW_MAX_NS) / (`PRC_CLK_NS))
`define PRC_LOW_CNT_W 4

// Refresh interval, hot worst case and below 40 C, ns
`define PRC_REF_HOT_NS 7800
`define PRC_REF_COLD_NS 31200
`define PRC_REF_HOT_CYC ((`PRC_REF_HOT_NS) / (`PRC_CLK_NS))
`define PRC_REF_COLD_CYC ((`PRC_REF_COLD_NS) / (`PRC_CLK_NS))
`define PRC_REF_CNT_W 10

// Block count selection codes
`define PRC_BLK_FOUR 2'h0
`define PRC_BLK_THREE 2'h1
`define PRC_BLK_TWO 2'h2
`define PRC_BLK_ONE 2'h3

// Retained range limits, bottom array selection
`define PRC_BOT_END_3 22'h2fffff
`define PRC_BOT_END_2 22'h1fffff
`define PRC_BOT_END_1 22'h0fffff
// Retained range limits, top array selection
`define PRC_TOP_START_3 22'h100000
`define PRC_TOP_START_2 22'h200000
`define PRC_TOP_START_1 22'h300000

// Drive strength codes and leg enables
`define PRC_DRV_FULL 2'h0
`define PRC_DRV_HALF 2'h1
`define PRC_DRV_QUARTER 2'h2
`define PRC_LEGS_FULL 4'hf
`define PRC_LEGS_HALF 4'h3
`define PRC_LEGS_QUARTER 4'h1

`endif

/* File: core/prc_pace_if.sv */
// Link between controller and refresh pacer
interface prc_pace_if;
   logic cold;
   logic tick;

   modport pacer
   (
      input cold,
      output tick
   );
   modport ctrl
   (
      output cold,
      input tick
   );
endinterface

/* File: core/prc_pkg.sv */
// Types for the partial array refresh controller
package prc_pkg;

   // Partial refresh entry state machine
   typedef enum logic [2:0]
   {
      PRC_NORMAL = 3'b001,
      PRC_ARMING = 3'b010,
      PRC_EXEC = 3'b100
   } prc_state_e;

   typedef logic [1:0] prc_blk_t;

endpackage

/* File: core/prc_refresh_ctrl.sv */
// Partial array refresh control: entry, retained range, refresh rows, drive
// How it works
// - Array splits in four blocks; one to four are kept refreshed.
// - In partial refresh only selected blocks refresh; others lose data.
// - Selection alone does nothing; mode-set pin low executes it.
// - Accesses stay allowed while mode-set pin low no longer than 0.5 us.
// - Mode-set pin high leaves partial refresh, normal operation resumes.
// - Bottom selection keeps zero up to 2fffff, 1fffff or 0fffff.
// - Top selection keeps up to 3fffff from 100000, 200000 or 300000.
// - Output drive strength full, half or quarter from configuration.
// - Refresh interval lengthens below 40 C, worst case otherwise.
`include "prc_defs.svh"
module prc_refresh_ctrl
   import prc_pkg::*;
#(
   parameter int ROW_W = `PRC_ROW_W
)
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_mode_set_pin_n,
   input wire logic i_temp_below_40,
   input wire logic i_partial_refresh_mode_en,
   input wire logic [1:0] i_blocks_sel,
   input wire logic i_top_array_sel,
   input wire logic [1:0] i_drive_sel,
   input wire logic i_access_req,
   input wire logic [`PRC_ADDR_W-1:0] i_access_addr,
   output logic o_access_grant,
   output logic o_addr_retained,
   output logic o_partial_active,
   output logic [3:0] o_block_refresh_en,
   output logic o_refresh_req,
   output logic [ROW_W+1:0] o_refresh_row,
   output logic [3:0] o_drive_leg_en
);
   localparam logic [`PRC_LOW_CNT_W-1:0] LOW_MAX = `PRC_LOW_CNT_W'(`PRC_LOW_MAX_CYC);

   prc_pace_if pace_if ();

   prc_refresh_pacer u_pacer
   (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .pace(pace_if.pacer)
   );

   // Pin and sensor synchronisers
   logic pin_s1_r;
   logic pin_s2_r;
   logic tmp_s1_r;
   logic tmp_s2_r;
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         pin_s1_r <= 1'b1;
         pin_s2_r <= 1'b1;
         tmp_s1_r <= 1'b0;
         tmp_s2_r <= 1'b0;
      end
      else
      begin
         pin_s1_r <= i_mode_set_pin_n;
         pin_s2_r <= pin_s1_r;
         tmp_s1_r <= i_temp_below_40;
         tmp_s2_r <= tmp_s1_r;
      end
   end

   assign pace_if.cold = tmp_s2_r;

   // Entry state machine
   prc_state_e state_r;
   prc_state_e state_nxt;
   logic [`PRC_LOW_CNT_W-1:0] cnt_r;
   logic [`PRC_LOW_CNT_W-1:0] cnt_nxt;
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         PRC_NORMAL:
         begin
            // Needs both enable and pin low
            if (!pin_s2_r && i_partial_refresh_mode_en)
            begin
               state_nxt = PRC_ARMING;
               cnt_nxt = `PRC_LOW_CNT_W'(1);
            end
         end
         PRC_ARMING:
         begin
            // Short low pulses keep normal mode
            if (pin_s2_r || !i_partial_refresh_mode_en)
               state_nxt = PRC_NORMAL;
            else if (cnt_r == LOW_MAX)
               state_nxt = PRC_EXEC;
            else
               cnt_nxt = cnt_r + `PRC_LOW_CNT_W'(1);
         end
         PRC_EXEC:
         begin
            if (pin_s2_r)
               state_nxt = PRC_NORMAL;
         end
         default: state_nxt = PRC_NORMAL;
      endcase
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         state_r <= PRC_NORMAL;
         cnt_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign o_partial_active = (state_r == PRC_EXEC);
   assign o_access_grant = i_access_req && (state_r != PRC_EXEC);

   // Retained block range
   prc_blk_t first_blk;
   prc_blk_t last_blk;
   logic [3:0] keep_mask;
   always_comb
   begin
      first_blk = 2'h0;
      last_blk = 2'h3;
      if (state_r == PRC_EXEC)
      begin
         if (i_top_array_sel)
            first_blk = i_blocks_sel;
         else
            last_blk = ~i_blocks_sel;
      end
   end

   for (genvar b = 0; b < 4; b++)
   begin : g_keep
      assign keep_mask[b] = (2'(b) >= first_blk) && (2'(b) <= last_blk);
   end

   // Refresh row generator and retained address check
   logic [ROW_W+1:0] row_r;
   logic [ROW_W+1:0] row_nxt;
   logic [ROW_W+1:0] row_cur;
   logic [ROW_W+1:0] out_row_nxt;
   logic req_nxt;
   logic [3:0] keep_nxt;
   logic ret_nxt;
   prc_blk_t cur_blk;
   always_comb
   begin
      row_nxt = row_r;
      req_nxt = 1'b0;
      keep_nxt = keep_mask;
      // Jump into range when outside it
      if (row_r[ROW_W+1:ROW_W] < first_blk || row_r[ROW_W+1:ROW_W] > last_blk)
         row_cur = {first_blk, {ROW_W{1'b0}}};
      else
         row_cur = row_r;
      cur_blk = row_cur[ROW_W+1:ROW_W];
      out_row_nxt = o_refresh_row;
      if (pace_if.tick)
      begin
         req_nxt = 1'b1;
         out_row_nxt = row_cur;
         // Wrap back to first retained block
         if (&row_cur[ROW_W-1:0])
            row_nxt = (cur_blk == last_blk) ? {first_blk, {ROW_W{1'b0}}}
                                            : {cur_blk + 2'h1, {ROW_W{1'b0}}};
         else
            row_nxt = row_cur + (ROW_W+2)'(1);
      end
      ret_nxt = 1'b1;
      if (state_r == PRC_EXEC)
      begin
         if (i_top_array_sel)
         begin
            case (i_blocks_sel)
               `PRC_BLK_THREE: ret_nxt = i_access_addr >= `PRC_TOP_START_3;
               `PRC_BLK_TWO: ret_nxt = i_access_addr >= `PRC_TOP_START_2;
               `PRC_BLK_ONE: ret_nxt = i_access_addr >= `PRC_TOP_START_1;
               default: ret_nxt = 1'b1;
            endcase
         end
         else
         begin
            case (i_blocks_sel)
               `PRC_BLK_THREE: ret_nxt = i_access_addr <= `PRC_BOT_END_3;
               `PRC_BLK_TWO: ret_nxt = i_access_addr <= `PRC_BOT_END_2;
               `PRC_BLK_ONE: ret_nxt = i_access_addr <= `PRC_BOT_END_1;
               default: ret_nxt = 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         row_r <= '0;
         o_refresh_row <= '0;
         o_refresh_req <= 1'b0;
         o_block_refresh_en <= 4'hf;
         o_addr_retained <= 1'b1;
      end
      else
      begin
         row_r <= row_nxt;
         o_refresh_row <= out_row_nxt;
         o_refresh_req <= req_nxt;
         o_block_refresh_en <= keep_nxt;
         o_addr_retained <= ret_nxt;
      end
   end

   // Drive strength legs
   logic [3:0] leg_nxt;
   always_comb
   begin
      case (i_drive_sel)
         `PRC_DRV_HALF: leg_nxt = `PRC_LEGS_HALF;
         `PRC_DRV_QUARTER: leg_nxt = `PRC_LEGS_QUARTER;
         default: leg_nxt = `PRC_LEGS_FULL;
      endcase
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         o_drive_leg_en <= `PRC_LEGS_FULL;
      else
         o_drive_leg_en <= leg_nxt;
   end

   // Helper: consecutive synchronised low cycles of the pin
   logic [4:0] low_run_r;
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst || pin_s2_r)
         low_run_r <= '0;
      else if (low_run_r != 5'h1f)
         low_run_r <= low_run_r + 5'h1;
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   short_low_access_a: assert property (
      i_access_req && low_run_r <= 5'd10 |-> o_access_grant)
      else $error("access refused before low time limit");
   exec_needs_long_a: assert property (
      o_partial_active |-> low_run_r >= 5'd11)
      else $error("partial refresh entered too early");
   exec_needs_enable_a: assert property (
      $rose(o_partial_active) |-> $past(i_partial_refresh_mode_en) && $past(!pin_s2_r))
      else $error("partial refresh entered without enable");
   pin_high_exit_a: assert property (
      $rose(pin_s2_r) |=> !o_partial_active)
      else $error("partial refresh not left on pin high");
   full_refresh_a: assert property (
      !o_partial_active |=> o_block_refresh_en == 4'hf)
      else $error("blocks dropped outside partial refresh");
   block_count_a: assert property (
      o_partial_active |=> $countones(o_block_refresh_en) == 4 - int'($past(i_blocks_sel)))
      else $error("wrong number of refreshed blocks");
   row_in_range_a: assert property (
      o_refresh_req |-> o_block_refresh_en[o_refresh_row[ROW_W+1:ROW_W]])
      else $error("refresh issued to a dropped block");
   bottom_range_a: assert property (
      o_partial_active && !i_top_array_sel && i_blocks_sel == 2'h3 && i_access_addr == 22'h100000
      |=> !o_addr_retained)
      else $error("bottom range end wrong");
   top_range_a: assert property (
      o_partial_active && i_top_array_sel && i_blocks_sel == 2'h2 && i_access_addr == 22'h200000
      |=> o_addr_retained)
      else $error("top range start wrong");
   quarter_drive_a: assert property (
      i_drive_sel == 2'h2 |=> o_drive_leg_en == 4'h1)
      else $error("quarter drive legs wrong");
endmodule

/* File: core/prc_refresh_pacer.sv */
// Temperature compensated refresh interval timer
`include "prc_defs.svh"
module prc_refresh_pacer
   import prc_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   prc_pace_if.pacer pace
);
   localparam logic [`PRC_REF_CNT_W-1:0] HOT_RELOAD = `PRC_REF_CNT_W'(`PRC_REF_HOT_CYC - 1);
   localparam logic [`PRC_REF_CNT_W-1:0] COLD_RELOAD = `PRC_REF_CNT_W'(`PRC_REF_COLD_CYC - 1);

   logic [`PRC_REF_CNT_W-1:0] cnt_r;
   logic [`PRC_REF_CNT_W-1:0] cnt_nxt;
   logic tick_r;
   logic tick_nxt;

   // Countdown, reload picks the interval
   always_comb
   begin
      cnt_nxt = cnt_r - `PRC_REF_CNT_W'(1);
      tick_nxt = 1'b0;
      if (cnt_r == '0)
      begin
         cnt_nxt = pace.cold ? COLD_RELOAD : HOT_RELOAD;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         cnt_r <= HOT_RELOAD;
         tick_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign pace.tick = tick_r;

   // Helper: gap since last tick and the interval chosen for that gap
   logic [`PRC_REF_CNT_W-1:0] gap_r;
   logic cold_now_r;
   logic cold_sel_r;
   logic seen_r;
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         gap_r <= '0;
         cold_now_r <= 1'b0;
         cold_sel_r <= 1'b0;
         seen_r <= 1'b0;
      end
      else
      begin
         gap_r <= tick_r ? '0 : gap_r + `PRC_REF_CNT_W'(1);
         if (cnt_r == '0)
            cold_now_r <= pace.cold;
         // Choice moves on only after the ending gap has been checked
         if (tick_r)
         begin
            cold_sel_r <= cold_now_r;
            seen_r <= 1'b1;
         end
      end
   end

   refresh_period_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      tick_r && seen_r |-> gap_r == (cold_sel_r ? COLD_RELOAD : HOT_RELOAD))
      else $error("refresh interval does not match temperature");
endmodule

/* File: verif/prc_host_model.sv */
// Host controller model that drives the mode-set pin
module prc_host_model
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_hold,
   input wire logic i_go,
   input wire logic [7:0] i_low_cyc,
   output logic o_mode_set_pin_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;

   // Load a timed low pulse or count it down
   always_comb
   begin
      cnt_nxt = cnt_r;
      if (i_go)
         cnt_nxt = i_low_cyc;
      else if (cnt_r != 8'h00)
         cnt_nxt = cnt_r - 8'h01;
   end

   // Pulse length register
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         cnt_r <= 8'h00;
      else
         cnt_r <= cnt_nxt;
   end

   assign o_mode_set_pin_n = ~(i_hold | (cnt_r != 8'h00));
endmodule

/* File: verif/prc_refresh_ctrl_tb.sv */
// Self-checking bench for the partial array refresh controller
`include "prc_defs.svh"
module prc_refresh_ctrl_tb
   import prc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [1:0] drv; logic req; logic [3:0] legs; logic grant;} prc_row_s;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic temp = 1'b0;
   logic en = 1'b1;
   logic top = 1'b0;
   logic req = 1'b0;
   logic hold = 1'b0;
   logic go = 1'b0;
   logic [7:0] low_cyc = 8'h00;
   prc_blk_t blk = 2'h0;
   logic [1:0] drv = 2'h0;
   logic [`PRC_ADDR_W-1:0] addr = '0;
   logic pin_n, grant, retained, active, ref_req;
   logic [3:0] blk_en, legs;
   logic [13:0] row;
   int fails = 0;
   int n_compared = 0;
   prc_row_s rows [4] = '{'{2'h0, 1'b1, 4'hf, 1'b1}, '{2'h1, 1'b0, 4'h3, 1'b0},
                          '{2'h2, 1'b1, 4'h1, 1'b1}, '{2'h3, 1'b1, 4'hf, 1'b1}};

   // Clock at 50 ns
   always #25 i_clk_sys = ~i_clk_sys;

   prc_host_model host (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_hold(hold), .i_go(go),
      .i_low_cyc(low_cyc), .o_mode_set_pin_n(pin_n));

   prc_refresh_ctrl dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_mode_set_pin_n(pin_n),
      .i_temp_below_40(temp), .i_partial_refresh_mode_en(en), .i_blocks_sel(blk),
      .i_top_array_sel(top), .i_drive_sel(drv), .i_access_req(req), .i_access_addr(addr),
      .o_access_grant(grant), .o_addr_retained(retained), .o_partial_active(active),
      .o_block_refresh_en(blk_en), .o_refresh_req(ref_req), .o_refresh_row(row),
      .o_drive_leg_en(legs));

   task automatic chk(input logic [21:0] got, input logic [21:0] exp);
      begin
         n_compared++;
         if (got !== exp)
         begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
         end
      end
   endtask

   task automatic close_out;
      begin
         $display("counts: compared %0d, bad %0d", n_compared, fails);
         if (fails == 0 && n_compared > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask

   // Wait a bounded time for a flag, then confirm it
   task automatic wait_hi(ref logic s, input int lim);
      int k;
      begin
         k = 0;
         while (s !== 1'b1 && k < lim)
         begin
            @(negedge i_clk_sys);
            k++;
         end
         chk(22'(s), 22'h1);
      end
   endtask

   // Timed low pulse, watch for entry and lost grants
   task automatic try_entry(input logic [7:0] len, input logic e, input logic exp);
      logic seen;
      logic gr;
      begin
         seen = 1'b0;
         gr = 1'b1;
         @(posedge i_clk_sys);
         en <= e;
         blk <= 2'h2;
         req <= 1'b1;
         go <= 1'b1;
         low_cyc <= len;
         @(posedge i_clk_sys);
         go <= 1'b0;
         repeat (int'(len) + 20)
         begin
            @(negedge i_clk_sys);
            seen |= active;
            gr &= grant;
         end
         chk(seen, exp); // entry only after long low
         chk(gr, !exp); // grants lost only when executing
         $display("test entry %0d done", len);
      end
   endtask

   // Execute partial refresh for one selection, probe range edges, exit
   task automatic run_par(input logic [1:0] b, input logic t);
      logic [3:0] m;
      logic [21:0] lo;
      logic [21:0] hi;
      begin
         m = t ? 4'hf << b : 4'hf >> b;
         lo = t ? {b, 20'h00000} : 22'h000000;
         hi = t ? 22'h3fffff : {~b, 20'hfffff};
         @(posedge i_clk_sys);
         blk <= b;
         top <= t;
         hold <= 1'b1;
         wait_hi(active, 30); // pin low executes
         repeat (2) @(posedge i_clk_sys);
         @(negedge i_clk_sys);
         chk(blk_en, m); // kept blocks only
         chk(grant, 1'b0); // access refused
         for (int j = 0; j < 3; j++)
         begin
            @(posedge i_clk_sys);
            addr <= j == 0 ? lo : j == 1 ? hi : t ? lo - 22'h1 : hi + 22'h1;
            @(posedge i_clk_sys);
            @(negedge i_clk_sys);
            chk(retained, j < 2 || b == 2'h0); // range edges
         end
         wait_hi(ref_req, 700); // refresh keeps running
         chk(m[row[13:12]], 1'b1); // row in kept block
         @(posedge i_clk_sys);
         hold <= 1'b0;
         repeat (5) @(posedge i_clk_sys);
         @(negedge i_clk_sys);
         chk(active, 1'b0); // exit on high
         chk(blk_en, 4'hf); // whole array again
         $display("test partial %0d %0d done", b, t);
      end
   endtask

   // Cycles between two refresh pulses
   task automatic interval(output int k);
      begin
         wait_hi(ref_req, 700); // first pulse
         k = 1;
         @(negedge i_clk_sys);
         while (ref_req !== 1'b1 && k < 1000)
         begin
            @(negedge i_clk_sys);
            k++;
         end
      end
   endtask

   // Main sequence
   initial
   begin
      int k;
      repeat (6) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      @(negedge i_clk_sys);
      chk(active, 1'b0); // idle after reset
      chk({blk_en, legs}, 8'hff); // full refresh and drive
      chk(retained, 1'b1); // whole array valid
      $display("test reset done");
      for (int i = 0; i < 4; i++)
      begin
         @(posedge i_clk_sys);
         drv <= rows[i].drv;
         req <= rows[i].req;
         @(posedge i_clk_sys);
         @(negedge i_clk_sys);
         chk(legs, rows[i].legs); // leg enables
         chk(grant, rows[i].grant); // grant outside execution
      end
      $display("test table done");
      try_entry(8'h0a, 1'b1, 1'b0); // short low keeps access
      try_entry(8'h0b, 1'b1, 1'b1); // longer low executes
      try_entry(8'hff, 1'b0, 1'b0); // pin low without enable is inert
      @(posedge i_clk_sys);
      en <= 1'b1;
      for (int b = 0; b < 8; b++)
         run_par(2'(b), b >= 4);
      @(posedge i_clk_sys);
      hold <= 1'b1;
      wait_hi(active, 30); // execute before reset
      @(posedge i_clk_sys);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      hold <= 1'b0;
      @(negedge i_clk_sys);
      chk(active, 1'b0); // reset leaves execution
      $display("test mid reset done");
      interval(k); // hot pacing
      chk(22'(k), 22'd156); // hot interval
      chk(row, 22'h1); // rows step up from row 0
      @(posedge i_clk_sys);
      temp <= 1'b1;
      interval(k); // first cold gap
      interval(k); // second cold gap
      chk(22'(k), 22'd624); // cold interval
      $display("test pacing done");
      close_out();
   end

   // Watchdog against a hang
   initial
   begin
      repeat (20000) @(posedge i_clk_sys);
      fails++;
      close_out();
   end
endmodule
